// ---- hdl/i2c_bit_rate_timing.sv ----
// Bit-rate and hold timing generator for a two-wire serial bus, with a Wishbone register port.
//
// Summary of operation
// - Rate index and multiplier together pick the divider and all three hold values.
// - After each falling SCL edge, SDA changes only after clock period times mul times SDA hold.
// - For a start, SCL stays high after SDA falls for period times mul times start hold.
// - For a stop, SDA is released after SCL rises by period times mul times stop hold.
// - The rate index offers sixty-four SCL frequency choices chosen by software.
//
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "i2c_timing_map.svh"

module i2c_bit_rate_timing
    import i2c_timing_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Serial clock pin
    input wire logic sclIn,
    output logic sclOut,
    output logic sclOe,
    // Serial data pin
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe
);

    // ======================================================================
    // Declarations
    logic [7:0] bitRateDivider;
    logic [1:0] rateMultiplierSelect;
    logic [5:0] clockRateIndex;
    rate_entry_t tableEntry;
    rate_entry_t activeEntry;
    logic [1:0] prescaleCount;
    logic [1:0] prescaleLast;
    logic tick;
    logic [11:0] tickCount;
    logic countDone;
    seq_state_t state;
    logic txBit;
    logic rxBit;
    logic busAccess;
    logic writeAccess;
    logic cmdWrite;
    logic [11:0] halfDivider;

    // Address match, shared by the write and read decoders.
    function automatic logic hitsOffset(input logic [7:0] adr, input logic [7:0] ofs);
        hitsOffset = (adr[7:2] == ofs[7:2]);
    endfunction : hitsOffset

    // A count of zero would stall the sequencer, so it is raised to one tick.
    function automatic logic [11:0] atLeastOne(input logic [11:0] value);
        atLeastOne = (value == 12'h000) ? 12'h001 : value;
    endfunction : atLeastOne

    assign rateMultiplierSelect = bitRateDivider[`RATE_RATE_MULTIPLIER_SELECT_HI:`RATE_RATE_MULTIPLIER_SELECT_LO];
    assign clockRateIndex = bitRateDivider[`RATE_INDEX_HI:`RATE_INDEX_LO];

    // ======================================================================
    // Wishbone decode: one new request per ack, ack drops the cycle after.
    assign busAccess = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign writeAccess = busAccess && wb_we_i && wb_sel_i[0];
    assign cmdWrite = writeAccess && hitsOffset(wb_adr_i, `OFS_BUS_COMMAND);

    // Answer every access, mapped or not, one cycle after it is seen.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= busAccess;
        end
    end

    // Rate register; index and multiplier are both software visible.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            bitRateDivider <= `BIT_RATE_DIVIDER_RESET;
        end else if (writeAccess && hitsOffset(wb_adr_i, `OFS_BIT_RATE_DIVIDER)) begin
            bitRateDivider <= wb_dat_i[7:0];
        end
    end

    // Read data; unmapped offsets and unused bits read as zero.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (busAccess && !wb_we_i) begin
            wb_dat_o <= 32'h0000_0000;
            if (hitsOffset(wb_adr_i, `OFS_BIT_RATE_DIVIDER)) begin
                wb_dat_o[7:0] <= bitRateDivider;
            end else if (hitsOffset(wb_adr_i, `OFS_BUS_STATUS)) begin
                wb_dat_o[`STAT_BUSY_BIT] <= (state != ST_IDLE);
                wb_dat_o[`STAT_RXBIT_BIT] <= rxBit;
                wb_dat_o[`STAT_SCL_BIT] <= sclIn;
                wb_dat_o[`STAT_SDA_BIT] <= sdaIn;
            end
        end
    end

    // ======================================================================
    // Lookup of divider and hold values.
    i2c_divider_table rateTable (
        .clockRateIndex(clockRateIndex),
        .entry(tableEntry)
    );

    // Registered copy of the entry, so table depth never sits in the counter path.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            activeEntry <= 48'h000_000_000_000;
        end else begin
            activeEntry <= tableEntry;
        end
    end

    assign halfDivider = {1'b0, activeEntry.sclDivider[11:1]};

    // ======================================================================
    // Multiplier prescaler: one tick every 1, 2 or 4 clocks. The reserved
    // code is run as a multiplier of one rather than freezing the bus.
    always_comb begin
        case (rateMultiplierSelect)
            `RATE_MULTIPLIER_SELECT_CODE_X2: prescaleLast = `PRESCALE_LAST_X2;
            `RATE_MULTIPLIER_SELECT_CODE_X4: prescaleLast = `PRESCALE_LAST_X4;
            default: prescaleLast = `PRESCALE_LAST_X1;
        endcase
    end

    assign tick = (prescaleCount >= prescaleLast);

    // Prescaler counter, restarted with each sequencer step for exact spacing.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prescaleCount <= 2'h0;
        end else if (tick || state == ST_IDLE) begin
            prescaleCount <= 2'h0;
        end else begin
            prescaleCount <= prescaleCount + 2'h1;
        end
    end

    assign countDone = tick && (tickCount == 12'h001);

    // ======================================================================
    // Bus sequencer. Every wait is a count of ticks, so each hold time is
    // clock period times multiplier times the table value. A bit takes
    // SDA hold plus the rest of the low half plus the high half, which is
    // the full divider. Clock stretching by a slave is not observed.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            tickCount <= 12'h001;
            sclOe <= 1'b0;
            sdaOe <= 1'b0;
            txBit <= 1'b1;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (cmdWrite && wb_dat_i[`CMD_START_BIT]) begin
                        sdaOe <= 1'b1;
                        tickCount <= atLeastOne(activeEntry.startHold);
                        state <= ST_START_HOLD;
                    end else if (cmdWrite && wb_dat_i[`CMD_STOP_BIT]) begin
                        tickCount <= atLeastOne(activeEntry.sdaHold);
                        state <= ST_STOP_LOW;
                    end else if (cmdWrite && wb_dat_i[`CMD_XFER_BIT]) begin
                        txBit <= wb_dat_i[`CMD_DATA_BIT];
                        tickCount <= atLeastOne(activeEntry.sdaHold);
                        state <= ST_LOW_HOLD;
                    end
                end
                ST_START_HOLD: begin
                    if (countDone) begin
                        sclOe <= 1'b1;
                        state <= ST_IDLE;
                    end else if (tick) begin
                        tickCount <= tickCount - 12'h001;
                    end
                end
                ST_LOW_HOLD: begin
                    if (countDone) begin
                        sdaOe <= !txBit;
                        tickCount <= atLeastOne(halfDivider - activeEntry.sdaHold);
                        state <= ST_LOW_REST;
                    end else if (tick) begin
                        tickCount <= tickCount - 12'h001;
                    end
                end
                ST_LOW_REST: begin
                    if (countDone) begin
                        sclOe <= 1'b0;
                        tickCount <= atLeastOne(halfDivider);
                        state <= ST_HIGH;
                    end else if (tick) begin
                        tickCount <= tickCount - 12'h001;
                    end
                end
                ST_HIGH: begin
                    if (countDone) begin
                        sclOe <= 1'b1;
                        state <= ST_IDLE;
                    end else if (tick) begin
                        tickCount <= tickCount - 12'h001;
                    end
                end
                ST_STOP_LOW: begin
                    if (countDone) begin
                        sdaOe <= 1'b1;
                        tickCount <= atLeastOne(halfDivider - activeEntry.sdaHold);
                        state <= ST_STOP_RISE;
                    end else if (tick) begin
                        tickCount <= tickCount - 12'h001;
                    end
                end
                ST_STOP_RISE: begin
                    if (countDone) begin
                        sclOe <= 1'b0;
                        tickCount <= atLeastOne(activeEntry.stopHold);
                        state <= ST_STOP_HOLD;
                    end else if (tick) begin
                        tickCount <= tickCount - 12'h001;
                    end
                end
                ST_STOP_HOLD: begin
                    if (countDone) begin
                        sdaOe <= 1'b0;
                        state <= ST_IDLE;
                    end else if (tick) begin
                        tickCount <= tickCount - 12'h001;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Received bit, sampled at the end of the high half just before SCL falls.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rxBit <= 1'b0;
        end else if (state == ST_HIGH && countDone) begin
            rxBit <= sdaIn;
        end
    end

    // Open-drain pins only ever pull low; the level is set by the enable.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
        end else begin
            sclOut <= 1'b0;
            sdaOut <= 1'b0;
        end
    end

endmodule : i2c_bit_rate_timing

`default_nettype wire

// ---- hdl/i2c_timing_map.svh ----
// Register offsets, field positions and reset values of the bit-rate and hold timing block.
`ifndef I2C_TIMING_MAP_SVH
`define I2C_TIMING_MAP_SVH

// ==========================================================================
// Register byte offsets on the Wishbone bus
`define OFS_BIT_RATE_DIVIDER 8'h00
`define OFS_BUS_COMMAND 8'h04
`define OFS_BUS_STATUS 8'h08

// ==========================================================================
// Field positions
`define RATE_RATE_MULTIPLIER_SELECT_HI 7
`define RATE_RATE_MULTIPLIER_SELECT_LO 6
`define RATE_INDEX_HI 5
`define RATE_INDEX_LO 0
`define CMD_START_BIT 0
`define CMD_STOP_BIT 1
`define CMD_XFER_BIT 2
`define CMD_DATA_BIT 3
`define STAT_BUSY_BIT 0
`define STAT_RXBIT_BIT 1
`define STAT_SCL_BIT 2
`define STAT_SDA_BIT 3

// ==========================================================================
// Reset values and multiplier codes
`define BIT_RATE_DIVIDER_RESET 8'h00
`define RATE_MULTIPLIER_SELECT_CODE_X1 2'h0
`define RATE_MULTIPLIER_SELECT_CODE_X2 2'h1
`define RATE_MULTIPLIER_SELECT_CODE_X4 2'h2
`define PRESCALE_LAST_X1 2'h0
`define PRESCALE_LAST_X2 2'h1
`define PRESCALE_LAST_X4 2'h3

`endif

// ---- hdl/i2c_timing_pkg.sv ----
// Types shared by the bit-rate and hold timing block.
package i2c_timing_pkg;

    // ======================================================================
    // Bus sequencer states, one-hot.
    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_START_HOLD = 8'h02,
        ST_LOW_HOLD = 8'h04,
        ST_LOW_REST = 8'h08,
        ST_HIGH = 8'h10,
        ST_STOP_LOW = 8'h20,
        ST_STOP_RISE = 8'h40,
        ST_STOP_HOLD = 8'h80
    } seq_state_t;

    // One lookup entry: SCL divider, SDA hold, SCL start hold, SCL stop hold.
    typedef struct packed {
        logic [11:0] sclDivider;
        logic [11:0] sdaHold;
        logic [11:0] startHold;
        logic [11:0] stopHold;
    } rate_entry_t;

endpackage : i2c_timing_pkg

// ---- hdl/i2c_divider_table.sv ----
// Fixed SCL divider and hold value table, indexed by the clock-rate index.
`timescale 1ns/100ps
`default_nettype none

module i2c_divider_table
    import i2c_timing_pkg::*;
(
    // Index in
    input wire logic [5:0] clockRateIndex,
    // Entry out
    output rate_entry_t entry
);

    // ======================================================================
    // Purely combinational so that a new index takes effect on the next clock.
    always_comb begin
        case (clockRateIndex)
            6'h00: entry = 48'h014_007_006_00b;
            6'h01: entry = 48'h016_007_007_00c;
            6'h02: entry = 48'h018_008_008_00d;
            6'h03: entry = 48'h01a_008_009_00e;
            6'h04: entry = 48'h01c_009_00a_00f;
            6'h05: entry = 48'h01e_009_00b_010;
            6'h06: entry = 48'h022_00a_00d_012;
            6'h07: entry = 48'h028_00a_010_015;
            6'h08: entry = 48'h01c_007_00a_00f;
            6'h09: entry = 48'h020_007_00c_011;
            6'h0a: entry = 48'h024_009_00e_013;
            6'h0b: entry = 48'h028_009_010_015;
            6'h0c: entry = 48'h02c_00b_012_017;
            6'h0d: entry = 48'h030_00b_014_019;
            6'h0e: entry = 48'h038_00d_018_01d;
            6'h0f: entry = 48'h044_00d_01e_023;
            6'h10: entry = 48'h030_009_012_019;
            6'h11: entry = 48'h038_009_016_01d;
            6'h12: entry = 48'h040_00d_01a_021;
            6'h13: entry = 48'h048_00d_01e_025;
            6'h14: entry = 48'h050_011_022_029;
            6'h15: entry = 48'h058_011_026_02d;
            6'h16: entry = 48'h068_015_02e_035;
            6'h17: entry = 48'h080_015_03a_041;
            6'h18: entry = 48'h050_009_026_029;
            6'h19: entry = 48'h060_009_02e_031;
            6'h1a: entry = 48'h070_011_036_039;
            6'h1b: entry = 48'h080_011_03e_041;
            6'h1c: entry = 48'h090_019_046_049;
            6'h1d: entry = 48'h0a0_019_04e_051;
            6'h1e: entry = 48'h0c0_021_05e_061;
            6'h1f: entry = 48'h0f0_021_076_079;
            6'h20: entry = 48'h0a0_011_04e_051;
            6'h21: entry = 48'h0c0_011_05e_061;
            6'h22: entry = 48'h0e0_021_06e_071;
            6'h23: entry = 48'h100_021_07e_081;
            6'h24: entry = 48'h120_031_08e_091;
            6'h25: entry = 48'h140_031_09e_0a1;
            6'h26: entry = 48'h180_041_0be_0c1;
            6'h27: entry = 48'h1e0_041_0ee_0f1;
            6'h28: entry = 48'h140_021_09e_0a1;
            6'h29: entry = 48'h180_021_0be_0c1;
            6'h2a: entry = 48'h1c0_041_0de_0e1;
            6'h2b: entry = 48'h200_041_0fe_101;
            6'h2c: entry = 48'h240_061_11e_121;
            6'h2d: entry = 48'h280_061_13e_141;
            6'h2e: entry = 48'h300_081_17e_181;
            6'h2f: entry = 48'h3c0_081_1de_1e1;
            6'h30: entry = 48'h280_041_13e_141;
            6'h31: entry = 48'h300_041_17e_181;
            6'h32: entry = 48'h380_081_1be_1c1;
            6'h33: entry = 48'h400_081_1fe_201;
            6'h34: entry = 48'h480_0c1_23e_241;
            6'h35: entry = 48'h500_0c1_27e_281;
            6'h36: entry = 48'h600_101_2fe_301;
            6'h37: entry = 48'h780_101_3be_3c1;
            6'h38: entry = 48'h500_081_27e_281;
            6'h39: entry = 48'h600_081_2fe_301;
            6'h3a: entry = 48'h700_101_37e_381;
            6'h3b: entry = 48'h800_101_3fe_401;
            6'h3c: entry = 48'h900_181_47e_481;
            6'h3d: entry = 48'ha00_181_4fe_501;
            6'h3e: entry = 48'hc00_201_5fe_601;
            6'h3f: entry = 48'hf00_201_77e_781;
            default: entry = 48'h014_007_006_00b;
        endcase
    end

endmodule : i2c_divider_table

`default_nettype wire

// ---- tb/i2c_bit_rate_timing_properties.sv ----
// Concurrent checks for the bit-rate and hold timing block, bound to its ports.
`timescale 1ns/100ps
`default_nettype none

module i2c_bit_rate_timing_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pin enables
    input wire logic sclOe,
    input wire logic sdaOe
);
    // All checks run on the one block clock and sleep during reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // ======================================================================
    // Helper state
    // Entries timed exactly: index, divider, SDA hold, start hold, stop hold.
    localparam int IDX [5] = '{0, 7, 11, 20, 24};
    localparam int DV [5] = '{20, 40, 40, 80, 80};
    localparam int SD [5] = '{7, 10, 9, 17, 9};
    localparam int ST [5] = '{6, 16, 16, 34, 38};
    localparam int SP [5] = '{11, 21, 21, 41, 41};
    logic [7:0] divReg;
    logic [15:0] sclAge, sdaAge, cmdAge;
    logic sclPrev, sdaPrev, taken, known;
    int mulN, dvT, sdT, stT, spT;

    function automatic logic [15:0] sat(input logic [15:0] v);
        return (v == 16'hffff) ? v : v + 16'h1;
    endfunction : sat

    assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];

    // Expected cycle counts; other indices are left to the bench, whose table is partial too.
    always_comb begin
        mulN = (divReg[7:6] == 2'h1) ? 2 : ((divReg[7:6] == 2'h2) ? 4 : 1);
        known = 1'b0;
        dvT = 0;
        sdT = 0;
        stT = 0;
        spT = 0;
        for (int i = 0; i < 5; i++) begin
            if (int'(divReg[5:0]) == IDX[i]) begin
                known = 1'b1;
                dvT = DV[i] * mulN;
                sdT = SD[i] * mulN;
                stT = ST[i] * mulN;
                spT = SP[i] * mulN;
            end
        end
    end

    // Shadow of the divider register, written where the slave takes the request.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            divReg <= 8'h00;
        end else if (taken && wb_adr_i[7:2] == 6'h00) begin
            divReg <= wb_dat_i[7:0];
        end
    end

    // Ages in cycles since each pin enable changed and since the last command was taken.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclAge <= 16'hffff;
            sdaAge <= 16'hffff;
            cmdAge <= 16'hffff;
            sclPrev <= 1'b0;
            sdaPrev <= 1'b0;
        end else begin
            sclAge <= (sclOe != sclPrev) ? 16'h1 : sat(sclAge);
            sdaAge <= (sdaOe != sdaPrev) ? 16'h1 : sat(sdaAge);
            cmdAge <= (taken && wb_adr_i[7:2] == 6'h01) ? 16'h0 : sat(cmdAge);
            sclPrev <= sclOe;
            sdaPrev <= sdaOe;
        end
    end

    // ======================================================================
    // Assertions
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("Request not answered in the next cycle");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Acknowledge lasted more than one cycle");
    AST_DIVIDER_READBACK: assert property (wb_ack_o && !wb_we_i && wb_adr_i[7:2] == 6'h00
        |-> wb_dat_o == {24'h0, divReg}) else $error("Divider readback differs");
    AST_START_HOLD: assert property (known && $rose(sclOe) && sdaAge < sclAge
        |-> int'(sdaAge) == stT) else $error("Start hold length wrong");
    AST_SCL_HIGH_HALF: assert property (known && $rose(sclOe) && sdaAge >= sclAge
        |-> int'(sclAge) == dvT / 2) else $error("SCL high phase length wrong");
    AST_BIT_PERIOD: assert property (known && $rose(sclOe) && sdaAge >= sclAge
        |-> int'(cmdAge) == dvT) else $error("Bit period wrong");
    AST_SDA_HOLD: assert property (known && $changed(sdaOe) && sclOe
        |-> int'(cmdAge) == sdT) else $error("SDA hold delay wrong");
    AST_STOP_HOLD: assert property (known && $fell(sdaOe) && !sclOe
        |-> int'(sclAge) == spT) else $error("Stop hold length wrong");
endmodule : i2c_bit_rate_timing_properties

bind i2c_bit_rate_timing i2c_bit_rate_timing_properties i2c_bit_rate_timing_properties_inst (
    .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .sclOe(sclOe), .sdaOe(sdaOe));
`default_nettype wire

// ---- tb/i2c_bus_far_side.sv ----
// Model of the other devices on the two-wire bus: pull-ups and a target that can pull SDA.
`timescale 1ns/100ps
`default_nettype none

module i2c_bus_far_side (
    // Pin drivers of the block
    input wire logic sclOut,
    input wire logic sclOe,
    input wire logic sdaOut,
    input wire logic sdaOe,
    // Target pulls SDA low while high
    input wire logic pullSda,
    // Wire levels seen by the block
    output logic sclIn,
    output logic sdaIn
);
    // Released lines float up; no target stretches SCL, as the block does not wait for it.
    assign sclIn = sclOe ? sclOut : 1'b1;
    assign sdaIn = (sdaOe ? sdaOut : 1'b1) & !pullSda;
endmodule : i2c_bus_far_side
`default_nettype wire

// ---- tb/i2c_bit_rate_timing_test.sv ----
// Self-checking testbench for the bit-rate and hold timing block.
`timescale 1ns/100ps
`default_nettype none

module i2c_bit_rate_timing_test;
    // ======================================================================
    // Signals and expected table entries
    localparam int IDX [5] = '{0, 7, 11, 20, 24};
    localparam int DV [5] = '{20, 40, 40, 80, 80};
    localparam int SD [5] = '{7, 10, 9, 17, 9};
    localparam int ST [5] = '{6, 16, 16, 34, 38};
    localparam int SP [5] = '{11, 21, 21, 41, 41};
    logic clk, resetn, cyc, stb, we, ack, pullSda;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] datW, datR;
    logic sclOut, sclOe, sdaOut, sdaOe, sclIn, sdaIn;
    logic pScl = 1'b0;
    logic pSda = 1'b0;
    int nFail = 0;
    int nTests = 0;
    int cycle = 0;
    int tCmd, tSclRise, tSclFall, tSdaRise, tSdaFall, tSdaChange;

    i2c_bit_rate_timing i2c_bit_rate_timing_inst (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
        .wb_dat_o(datR), .wb_ack_o(ack), .sclIn(sclIn), .sclOut(sclOut), .sclOe(sclOe),
        .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe));
    i2c_bus_far_side i2c_bus_far_side_inst (.sclOut(sclOut), .sclOe(sclOe), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .pullSda(pullSda), .sclIn(sclIn), .sdaIn(sdaIn));

    // Clock of 40 ns.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Edge stamps; a pin change shows one edge after the edge that made it.
    always @(posedge clk) begin
        cycle = cycle + 1;
        if (cyc && stb && we && !ack && adr == 8'h04) tCmd = cycle;
        if (sclOe !== pScl && sclOe) tSclRise = cycle;
        if (sclOe !== pScl && !sclOe) tSclFall = cycle;
        if (sdaOe !== pSda) tSdaChange = cycle;
        if (sdaOe !== pSda && sdaOe) tSdaRise = cycle;
        if (sdaOe !== pSda && !sdaOe) tSdaFall = cycle;
        pScl = sclOe;
        pSda = sdaOe;
    end

    // ======================================================================
    // Tasks
    task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
        nTests++;
        if (got !== exp) begin
            nFail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_reg

    task automatic check_time(input int got, input int exp);
        nTests++;
        if (got != exp) begin
            nFail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_time

    // One classic Wishbone cycle; entered just after a rising edge.
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datW <= d;
        sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (ack !== 1'b1) begin
            nFail++;
            $display("Error at %0t: got %h expected %h", $time, ack, 1'b1);
        end
        r = datR;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : acc

    // Issues a bus command and polls busy; returns the last status word.
    task automatic step(input logic [7:0] cmd, output logic [31:0] r);
        int n;
        n = 0;
        acc(1'b1, 8'h04, {24'h0, cmd}, 4'h1, r);
        do begin
            acc(1'b0, 8'h08, 32'h0, 4'hf, r);
            n++;
        end while (r[0] !== 1'b0 && n < 1000);
        // A sequencer that never goes idle is a mismatch, not a silent skip.
        if (r[0] !== 1'b0) begin
            nFail++;
            $display("Error at %0t: got %h expected %h", $time, r, 32'h0);
        end
    endtask : step

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", nTests, nFail);
        if (nFail == 0 && nTests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    // Watchdog well beyond the roughly 10000 cycles the sequence needs.
    initial begin
        repeat (60000) @(posedge clk);
        nFail++;
        print_verdict();
    end

    // ======================================================================
    // Main sequence
    initial begin
        logic [31:0] r;
        logic [7:0] d;
        int m;
        resetn = 1'b0;
        {cyc, stb, we, pullSda} = 4'h0;
        adr = 8'h00;
        sel = 4'h0;
        datW = 32'h0;
        void'($urandom(32'hee265676));
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        acc(1'b0, 8'h00, 32'h0, 4'hf, r);
        check_reg(r, 32'h0);
        acc(1'b0, 8'h08, 32'h0, 4'hf, r);
        check_reg(r, 32'hc);
        acc(1'b0, 8'h10, 32'h0, 4'hf, r);
        check_reg(r, 32'h0);
        // Every index with a random multiplier and junk in the upper bytes.
        for (int i = 0; i < 64; i++) begin
            d = {2'($urandom()), 6'(i)};
            acc(1'b1, 8'h00, {24'($urandom()), d}, 4'h1, r);
            acc(1'b0, 8'h00, 32'h0, 4'hf, r);
            check_reg(r, {24'h0, d});
        end
        acc(1'b1, 8'h00, $urandom(), 4'he, r);
        acc(1'b0, 8'h00, 32'h0, 4'hf, r);
        check_reg(r, {24'h0, d});
        // Start, three bits and stop for each timed entry and every multiplier code.
        for (int i = 0; i < 5; i++) begin
            for (int c = 0; c < 4; c++) begin
                m = (c == 1) ? 2 : ((c == 2) ? 4 : 1);
                acc(1'b1, 8'h00, {24'h0, 2'(c), 6'(IDX[i])}, 4'h1, r);
                step(8'h01, r);
                check_time(tSclRise - tSdaRise, ST[i] * m);
                step(8'h0c, r);
                check_time(tSdaChange - tCmd, SD[i] * m + 1);
                check_time(tSclRise - tCmd, DV[i] * m + 1);
                check_time(tSclRise - tSclFall, DV[i] / 2 * m);
                check_reg(r, 32'ha);
                pullSda <= 1'b1;
                step(8'h0c, r);
                check_reg(r, 32'h0);
                pullSda <= 1'b0;
                step(8'h04, r);
                check_time(tSdaChange - tCmd, SD[i] * m + 1);
                step(8'h02, r);
                check_time(tSdaFall - tSclFall, SP[i] * m);
                check_reg(r, 32'hc);
            end
        end
        print_verdict();
    end
endmodule : i2c_bit_rate_timing_test
`default_nettype wire
